// file: include/sync_serial_bus_if.sv
// Serial bus wires between the channel and its far partner
interface sync_serial_bus_if;
  logic sck_dev;      // Clock driven by channel
  logic sck_dev_oe;   // Channel clock enable
  logic sck_far;      // Clock driven by partner
  logic sck_far_oe;   // Partner clock enable
  logic m2s_dev;      // Channel master data out
  logic m2s_dev_oe;
  logic m2s_far;      // Partner master data out
  logic m2s_far_oe;
  logic s2m_dev;      // Channel slave data out
  logic s2m_dev_oe;
  logic s2m_far;      // Partner slave data out
  logic s2m_far_oe;
  logic sel_far;      // Select line, always driven by partner
  logic sck;          // Resolved clock line
  logic m2s;          // Resolved master-to-slave line
  logic s2m;          // Resolved slave-to-master line
  // Undriven lines float high through a pull-up
  assign sck = sck_dev_oe ? sck_dev : (sck_far_oe ? sck_far : 1'b1);
  assign m2s = m2s_dev_oe ? m2s_dev : (m2s_far_oe ? m2s_far : 1'b1);
  assign s2m = s2m_dev_oe ? s2m_dev : (s2m_far_oe ? s2m_far : 1'b1);
  modport dev_end (
    output sck_dev, sck_dev_oe, m2s_dev, m2s_dev_oe, s2m_dev, s2m_dev_oe,
    input  sck, m2s, s2m, sel_far
  );
  modport far_end (
    output sck_far, sck_far_oe, m2s_far, m2s_far_oe, s2m_far, s2m_far_oe, sel_far,
    input  sck, m2s, s2m
  );
endinterface : sync_serial_bus_if

// file: include/sync_serial_pkg.sv
// Shared types for the select-mode serial channel
package sync_serial_pkg;
  // Transfer engine state
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_SHIFT
  } xfer_state_t;
endpackage : sync_serial_pkg

// file: include/sync_serial_regs.svh
// Timing and frame constants for the select-mode serial channel
`ifndef SYNC_SERIAL_REGS_SVH
`define SYNC_SERIAL_REGS_SVH
// Data bits per frame
`define FRAME_BITS      8
// Index of the last clock edge of a frame (16 edges, 0..15)
`define LAST_EDGE       4'hf
// Bit index of the 7th received bit, where overrun is judged
`define OVERRUN_BIT_IDX 3'h6
// Depth of the transmit FIFO in words
`define TX_FIFO_DEPTH   8
// Far-end master half period in reference clock cycles
`define FAR_HALF_PERIOD 8
// Reset value of the divider counter
`define DIV_RESET       8'h00
`endif

// file: sim/sync_serial_select_mode_chk.sv
// Bus-level assertions for the select-mode serial channel and its partner
module sync_serial_select_mode_chk (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // Line values and enables
  input wire logic sck_dev,
  input wire logic sck_dev_oe,
  input wire logic sck_far_oe,
  input wire logic m2s_dev_oe,
  input wire logic m2s_far_oe,
  input wire logic s2m_dev_oe,
  input wire logic s2m_far_oe,
  input wire logic sel_far
);
  timeunit 1ns;
  timeprecision 1ps;
  // One clock domain, so clock and disable are given once
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  // Only one end may drive each line
  AST_SCK_ONE_DRIVER: assert property (!(sck_dev_oe && sck_far_oe))
    else $error("clock line driven by both ends");
  AST_M2S_ONE_DRIVER: assert property (!(m2s_dev_oe && m2s_far_oe))
    else $error("master data line driven by both ends");
  AST_S2M_ONE_DRIVER: assert property (!(s2m_dev_oe && s2m_far_oe))
    else $error("slave data line driven by both ends");
  // Select high long enough to pass the synchroniser releases the slave output
  AST_SLAVE_RELEASE: assert property (sel_far [*4] |-> !s2m_dev_oe)
    else $error("slave output driven while deselected");
  // Slave output only turns on once select has been low
  AST_SLAVE_ENABLE: assert property ($rose(s2m_dev_oe) |-> !sel_far && !$past(sel_far))
    else $error("slave output enabled without select");
  // Clock release only follows a low select: two sync stages and the flag edge
  AST_FAULT_RELEASE: assert property ($fell(sck_dev_oe) |-> !$past(sel_far, 3))
    else $error("clock released without low select");
  // Clock and data pins are released and restored together
  AST_OE_PAIRED: assert property (m2s_dev_oe == sck_dev_oe)
    else $error("clock and data enables differ");
  // Bench runs divider 5 or more: at least six cycles between clock edges
  AST_SCK_SPACING: assert property ($changed(sck_dev) && sck_dev_oe |=> $stable(sck_dev) [*5])
    else $error("clock edges too close");
  // Main scenarios reached
  cover property ($fell(sck_dev_oe));
  cover property ($rose(sck_dev_oe));
  cover property ($rose(s2m_dev_oe));
endmodule : sync_serial_select_mode_chk

// file: sim/sync_serial_select_mode_test.sv
// Self-checking bench: channel and partner facing each other on one bus
module sync_serial_select_mode_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic       i_ref_clk, i_reset;                  // Clock and reset
  logic       role, select_function_enable, cpha, cpol, src, te, re;  // Channel setup
  logic       tx_valid, rx_read, mf_clr, ov_clr;   // Channel requests
  logic [7:0] div, tx_data, far_tx;                // Divider and data
  logic       far_master, force_low, far_start;    // Partner controls
  logic       sck_q;                               // Last clock line level
  wire  [7:0] rx_data, far_rx;                     // Received bytes
  wire        tx_ready, rx_valid, fault, ovr, tx_irq, rx_irq, busy, far_done;
  int         err_count, check_count, cyc, edges;  // Tallies
  sync_serial_bus_if sync_serial_bus_if_i ();
  sync_serial_select_mode sync_serial_select_mode_i (
    .i_ref_clk, .i_reset, .bus(sync_serial_bus_if_i), .i_role_select_bit(role),
    .i_select_function_enable(select_function_enable), .i_clock_phase_bit(cpha), .i_clock_polarity_bit(cpol),
    .i_tx_irq_source_select(src), .i_tx_enable_bit(te), .i_rx_enable_bit(re), .i_baud_divider(div),
    .i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .i_tx_data(tx_data), .o_rx_data(rx_data),
    .o_rx_valid(rx_valid), .i_rx_read(rx_read), .o_mode_fault(fault), .i_mode_fault_clear(mf_clr),
    .o_overrun(ovr), .i_overrun_clear(ov_clr), .o_tx_irq(tx_irq), .o_rx_irq(rx_irq), .o_busy(busy));
  // Both ends share polarity and phase wires, so they can never disagree
  sync_serial_far_end sync_serial_far_end_i (
    .i_ref_clk, .i_reset, .bus(sync_serial_bus_if_i), .i_is_master(far_master), .i_cpol(cpol),
    .i_cpha(cpha), .i_force_select_low(force_low), .i_start(far_start), .i_tx_data(far_tx),
    .o_rx_data(far_rx), .o_done(far_done), .o_busy());
  sync_serial_select_mode_chk sync_serial_select_mode_chk_i (
    .i_ref_clk, .i_reset, .sck_dev(sync_serial_bus_if_i.sck_dev),
    .sck_dev_oe(sync_serial_bus_if_i.sck_dev_oe), .sck_far_oe(sync_serial_bus_if_i.sck_far_oe),
    .m2s_dev_oe(sync_serial_bus_if_i.m2s_dev_oe), .m2s_far_oe(sync_serial_bus_if_i.m2s_far_oe),
    .s2m_dev_oe(sync_serial_bus_if_i.s2m_dev_oe), .s2m_far_oe(sync_serial_bus_if_i.s2m_far_oe),
    .sel_far(sync_serial_bus_if_i.sel_far));
  // Free-running reference clock, 20 ns period
  initial begin
    i_ref_clk = 0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end
  // Count clock line edges; the ceiling cuts a hung run short
  always @(posedge i_ref_clk) begin
    cyc++;
    if (sync_serial_bus_if_i.sck !== sck_q) edges++;
    sck_q = sync_serial_bus_if_i.sck;
    if (cyc == 20000) begin
      err_count++;
      results();
    end
  end
  // Compare one value, report and count a mismatch
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Counts and verdict, then stop
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  // Reset with a new setup; roles and pin use are all set before release, so no bus fight
  task automatic setup(input logic r, s, p, o, q);
    @(negedge i_ref_clk);
    i_reset = 1;
    {role, select_function_enable, cpha, cpol, src} = {r, s, p, o, q};
    far_master = r;
    repeat (2) @(negedge i_ref_clk);
    i_reset = 0;
    // Let the clock line settle to its idle level through both synchronisers,
    // or an armed slave would take the settling step as a clock edge
    repeat (4) @(negedge i_ref_clk);
  endtask : setup
  // Push one word into the transmit FIFO, holding valid until taken
  task automatic push(input logic [7:0] d);
    @(negedge i_ref_clk);
    tx_data = d;
    tx_valid = 1;
    repeat (50) if (tx_ready !== 1) @(negedge i_ref_clk);
    @(negedge i_ref_clk);
    tx_valid = 0;
  endtask : push
  // Arm the partner with its next byte
  task automatic arm(input logic [7:0] d);
    @(negedge i_ref_clk);
    far_tx = d;
    far_start = 1;
    @(negedge i_ref_clk);
    far_start = 0;
  endtask : arm
  // Wait, bounded, for the channel receive pulse (0) or partner done (1)
  task automatic wait_hi(input int which);
    repeat (600) begin
      @(negedge i_ref_clk);
      if ((which == 0 ? rx_irq : far_done) === 1) break;
    end
  endtask : wait_hi
  // Master frames in all four clock modes, tx event source alternating
  task automatic t_modes();
    for (int k = 0; k < 4; k++) begin
      setup(0, 1, k[0], k[1], k[0]);
      check(8'(sync_serial_bus_if_i.sck), 8'(k[1]));
      arm(8'(8'h3c + k));
      edges = 0;
      push(8'(8'hc5 ^ k));
      wait_hi(0);
      check(rx_data, 8'(8'h3c + k));
      check(8'(tx_irq), 8'(k[0]));
      repeat (20) @(negedge i_ref_clk);
      check(far_rx, 8'(8'hc5 ^ k));
      check(8'(edges), 8'h10);
    end
    $display("test modes done");
  endtask : t_modes
  // Slave frames driven by the partner as master
  task automatic t_slave();
    for (int k = 0; k < 2; k++) begin
      setup(1, 1, k[0], k[0], 1);
      check(8'(sync_serial_bus_if_i.s2m_dev_oe), 8'h00);
      push(8'(8'h96 + k));
      arm(8'(8'h5a - k));
      wait_hi(1);
      check(far_rx, 8'(8'h96 + k));
      repeat (6) @(negedge i_ref_clk);
      check(rx_data, 8'(8'h5a - k));
    end
    $display("test slave done");
  endtask : t_slave
  // Mode fault from a low select, refused clear, then recovery
  // Idle clock high matches the pull-up, so the released line shows no edge on recovery
  task automatic t_fault();
    force_low = 1;
    setup(0, 1, 0, 1, 1);
    push(8'ha5);
    repeat (10) @(negedge i_ref_clk);
    check(8'(fault), 8'h01);
    check(8'(sync_serial_bus_if_i.sck_dev_oe), 8'h00);
    check(8'(busy), 8'h00);
    mf_clr = 1;
    @(negedge i_ref_clk);
    mf_clr = 0;
    repeat (4) @(negedge i_ref_clk);
    check(8'(fault), 8'h01);
    force_low = 0;
    arm(8'h0f);
    repeat (4) @(negedge i_ref_clk);
    check(8'(busy), 8'h00);
    mf_clr = 1;
    @(negedge i_ref_clk);
    mf_clr = 0;
    wait_hi(0);
    check(8'(fault), 8'h00);
    check(8'(sync_serial_bus_if_i.m2s_dev_oe), 8'h01);
    check(rx_data, 8'h0f);
    $display("test fault done");
  endtask : t_fault
  // Select function off: a low select changes nothing
  task automatic t_nosel();
    force_low = 1;
    setup(0, 0, 1, 0, 0);
    arm(8'h81);
    push(8'h18);
    wait_hi(0);
    check(8'(fault), 8'h00);
    check(rx_data, 8'h81);
    force_low = 0;
    $display("test select off done");
  endtask : t_nosel
  // Fill the FIFO while stopped, drain it in order, provoke overrun
  task automatic t_fifo();
    te = 0;
    div = 8'h09;
    setup(0, 1, 0, 0, 0);
    for (int k = 0; k < 8; k++) push(8'(8'h10 + k));
    check(8'(tx_ready), 8'h00);
    check(8'(busy), 8'h00);
    arm(8'h77);
    te = 1;
    for (int k = 0; k < 8; k++) begin
      wait_hi(1);
      check(far_rx, 8'(8'h10 + k));
      if (k == 0) check(8'(ovr), 8'h00);
      if (k < 7) arm(8'(8'h70 + k));
    end
    check(8'(ovr), 8'h01);
    check(rx_data, 8'h77);
    @(negedge i_ref_clk);
    rx_read = 1;
    ov_clr = 1;
    @(negedge i_ref_clk);
    rx_read = 0;
    ov_clr = 0;
    @(negedge i_ref_clk);
    check({6'h00, ovr, rx_valid}, 8'h00);
    div = 8'h05;
    $display("test fifo done");
  endtask : t_fifo
  // Idle values at time zero, reset for two cycles, then the scenarios
  initial begin
    {i_reset, role, select_function_enable, cpha, cpol, src, te, re} = 8'h83;
    {tx_valid, rx_read, mf_clr, ov_clr, far_master, force_low, far_start} = 7'h00;
    {div, tx_data, far_tx} = {8'h05, 8'h00, 8'h00};
    {err_count, check_count, cyc, edges} = {32'h0, 32'h0, 32'h0, 32'h0};
    sck_q = 1;
    repeat (2) @(negedge i_ref_clk);
    i_reset = 0;
    t_modes();
    t_slave();
    t_fault();
    t_nosel();
    t_fifo();
    results();
  end
endmodule : sync_serial_select_mode_test

// file: src/sync_serial_far_end.sv
// Partner end: a plain master or slave on the same serial bus
`include "sync_serial_regs.svh"

module sync_serial_far_end #(
  parameter int HALF_PERIOD = `FAR_HALF_PERIOD
) (
  // Clock and reset
  input  wire logic          i_ref_clk,
  input  wire logic          i_reset,
  // Serial bus pins
  sync_serial_bus_if.far_end bus,
  // Configuration levels
  input  wire logic          i_is_master,
  input  wire logic          i_cpol,
  input  wire logic          i_cpha,
  input  wire logic          i_force_select_low,
  // Transfer request and result
  input  wire logic          i_start,
  input  wire logic [7:0]    i_tx_data,
  output wire logic [7:0]    o_rx_data,
  output wire logic          o_done,
  output wire logic          o_busy
);
  logic [1:0]  sync1_ff;    // First stage: clock, data
  logic [1:0]  sync2_ff;    // Second stage, safe to read
  logic        sck_prev_ff; // Last synced clock level
  logic        busy_ff;     // Frame in flight
  logic [15:0] div_ff;      // Half-period counter
  logic [3:0]  edge_ff;     // Edge index in frame
  logic        sck_ff;      // Master clock level
  logic [7:0]  tx_sh_ff;    // Transmit shifter
  logic [7:0]  rx_sh_ff;    // Receive shifter
  logic [7:0]  rx_out_ff;   // Last received byte
  logic        done_ff;     // Completion pulse

  // Edge source follows role; same phase convention as the channel
  wire m_tick      = busy_ff && i_is_master && (div_ff == 16'(HALF_PERIOD - 1));
  wire s_edge      = busy_ff && !i_is_master && (sync2_ff[1] != sck_prev_ff);
  wire clk_edge    = i_is_master ? m_tick : s_edge;
  wire sample_edge = clk_edge && (edge_ff[0] == i_cpha);
  wire change_edge = clk_edge && (i_cpha ? (!edge_ff[0] && edge_ff != 4'h0)
                                         : (edge_ff[0] && edge_ff != `LAST_EDGE));
  wire done        = clk_edge && (edge_ff == `LAST_EDGE);
  wire [7:0] rx_upd = sample_edge ? {rx_sh_ff[6:0], sync2_ff[0]} : rx_sh_ff;

  // Pin synchronisers
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      sync1_ff    <= 2'h3;
      sync2_ff    <= 2'h3;
      sck_prev_ff <= 1'b1;
    end else begin
      sync1_ff    <= {bus.sck, (i_is_master ? bus.s2m : bus.m2s)};
      sync2_ff    <= sync1_ff;
      sck_prev_ff <= sync2_ff[1];
    end
  end

  // Frame engine
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      busy_ff   <= 1'b0;
      div_ff    <= 16'h0000;
      edge_ff   <= 4'h0;
      sck_ff    <= 1'b0;
      tx_sh_ff  <= 8'hff;
      rx_sh_ff  <= 8'h00;
      rx_out_ff <= 8'h00;
      done_ff   <= 1'b0;
    end else begin
      // Start is ignored while a frame runs
      if (i_start && !busy_ff) begin
        busy_ff  <= 1'b1;
        tx_sh_ff <= i_tx_data;
      end else if (done) begin
        busy_ff <= 1'b0;
      end
      if (change_edge) tx_sh_ff <= {tx_sh_ff[6:0], 1'b1};
      div_ff    <= (!busy_ff || m_tick) ? 16'h0000 : div_ff + 16'h0001;
      edge_ff   <= !busy_ff ? 4'h0 : edge_ff + 4'(clk_edge);
      sck_ff    <= !busy_ff ? i_cpol : (sck_ff ^ m_tick);
      rx_sh_ff  <= rx_upd;
      if (done) rx_out_ff <= rx_upd;
      done_ff   <= done;
    end
  end

  // Master drives clock and data; slave drives data only while armed
  assign bus.sck_far    = sck_ff;
  assign bus.sck_far_oe = i_is_master;
  assign bus.m2s_far    = tx_sh_ff[7];
  assign bus.m2s_far_oe = i_is_master;
  assign bus.s2m_far    = tx_sh_ff[7];
  assign bus.s2m_far_oe = !i_is_master && busy_ff;
  // As master, select low marks the frame and stays low one cycle past the last edge;
  // the slave syncs clock and select through equal stages, so an earlier release would
  // reach it together with the final edge and cut the frame short
  assign bus.sel_far    = i_is_master ? !(busy_ff || done_ff) : !i_force_select_low;

  assign o_rx_data = rx_out_ff;
  assign o_done    = done_ff;
  assign o_busy    = busy_ff;
endmodule : sync_serial_far_end

// file: src/sync_serial_select_mode.sv
// Select-mode serial channel (master or slave) with its transmit FIFO
`include "sync_serial_regs.svh"

// Transmit FIFO, parameterised width and depth
module tx_word_fifo #(
  parameter int WIDTH = `FRAME_BITS,
  parameter int DEPTH = `TX_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_reset,
  // Fill side
  input  wire logic             i_in_valid,
  output wire logic             o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output wire logic             o_out_valid,
  input  wire logic             i_out_ready,
  output wire logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];   // Storage array
  logic [AW:0]      wr_ptr_ff;     // Write pointer with wrap bit
  logic [AW:0]      rd_ptr_ff;     // Read pointer with wrap bit
  wire              empty = (wr_ptr_ff == rd_ptr_ff);
  wire              full  = (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]) && (wr_ptr_ff[AW] != rd_ptr_ff[AW]);
  wire              push  = i_in_valid && !full;
  wire              pop   = i_out_ready && !empty;
  assign o_in_ready  = !full;
  assign o_out_valid = !empty;
  assign o_out_data  = mem[rd_ptr_ff[AW-1:0]];
  // Storage has no reset; only pointers define contents
  always_ff @(posedge i_ref_clk) begin
    if (push) mem[wr_ptr_ff[AW-1:0]] <= i_in_data;
  end
  // Pointer update
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      wr_ptr_ff <= wr_ptr_ff + (AW+1)'(push);
      rd_ptr_ff <= rd_ptr_ff + (AW+1)'(pop);
    end
  end
endmodule : tx_word_fifo

module sync_serial_select_mode #(
  parameter int DIV_WIDTH = 8
) (
  // Clock and reset
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_reset,
  // Serial bus pins
  sync_serial_bus_if.dev_end        bus,
  // Configuration levels
  input  wire logic                 i_role_select_bit,
  input  wire logic                 i_select_function_enable,
  input  wire logic                 i_clock_phase_bit,
  input  wire logic                 i_clock_polarity_bit,
  input  wire logic                 i_tx_irq_source_select,
  input  wire logic                 i_tx_enable_bit,
  input  wire logic                 i_rx_enable_bit,
  input  wire logic [DIV_WIDTH-1:0] i_baud_divider,
  // Transmit stream
  input  wire logic                 i_tx_valid,
  output wire logic                 o_tx_ready,
  input  wire logic [7:0]           i_tx_data,
  // Receive buffer
  output wire logic [7:0]           o_rx_data,
  output wire logic                 o_rx_valid,
  input  wire logic                 i_rx_read,
  // Status and events
  output wire logic                 o_mode_fault,
  input  wire logic                 i_mode_fault_clear,
  output wire logic                 o_overrun,
  input  wire logic                 i_overrun_clear,
  output wire logic                 o_tx_irq,
  output wire logic                 o_rx_irq,
  output wire logic                 o_busy
);
  sync_serial_pkg::xfer_state_t state_ff, nxt_state;
  logic [2:0]           sync1_ff;      // First stage: clock, data, select
  logic [2:0]           sync2_ff;      // Second stage, safe to read
  logic                 sck_prev_ff;   // Last synced clock level
  logic [DIV_WIDTH-1:0] div_ff;        // Half-period counter
  logic [3:0]           edge_ff;       // Clock edge index in frame
  logic                 sck_ff;        // Master clock level
  logic [7:0]           tx_sh_ff;      // Transmit shifter
  logic [7:0]           rx_sh_ff;      // Receive shifter
  logic [7:0]           rx_buf_ff;     // Receive buffer
  logic                 rx_valid_ff;   // Receive buffer full
  logic                 fault_ff;      // Mode fault flag
  logic                 ovr_ff;        // Overrun flag
  logic                 tx_irq_ff;     // Transmit event pulse
  logic                 rx_irq_ff;     // Receive event pulse
  wire                  fifo_valid;
  wire  [7:0]           fifo_data;

  // Synced pin levels
  wire sck_in = sync2_ff[2];
  wire dat_in = sync2_ff[1];
  wire sel_in = sync2_ff[0];

  // Role and select decoding
  wire is_master    = !i_role_select_bit;
  wire select_function_enable          = i_select_function_enable;
  wire fault_set    = is_master && select_function_enable && !sel_in;
  wire fault_clr    = i_mode_fault_clear && sel_in;
  wire slave_active = !select_function_enable || !sel_in;
  wire shifting     = (state_ff == sync_serial_pkg::ST_SHIFT);

  // Clock edges: own divider as master, synced pin as slave
  wire m_tick   = shifting && is_master && (div_ff == i_baud_divider);
  wire s_edge   = shifting && !is_master && slave_active && (sck_in != sck_prev_ff);
  wire clk_edge = is_master ? m_tick : s_edge;
  wire abort    = shifting && (is_master ? (fault_set || fault_ff) : !slave_active);
  wire start    = !shifting && i_tx_enable_bit && fifo_valid
                  && (is_master ? (!select_function_enable || sel_in) && !fault_ff : slave_active);

  // Phase picks sampling edge: phase 0 leading, phase 1 trailing
  wire cpha        = i_clock_phase_bit;
  wire sample_edge = clk_edge && (edge_ff[0] == cpha);
  wire change_edge = clk_edge && (cpha ? (!edge_ff[0] && edge_ff != 4'h0)
                                       : (edge_ff[0] && edge_ff != `LAST_EDGE));
  wire done        = clk_edge && (edge_ff == `LAST_EDGE);
  wire rx_bit      = is_master ? dat_in : dat_in;
  wire [7:0] rx_upd = sample_edge ? {rx_sh_ff[6:0], rx_bit} : rx_sh_ff;
  wire store       = done && i_rx_enable_bit && !rx_valid_ff;
  wire ovr_set     = sample_edge && (edge_ff[3:1] == `OVERRUN_BIT_IDX)
                     && rx_valid_ff && i_rx_enable_bit;

  // Transmit FIFO; its drain stalls while a frame is in flight
  tx_word_fifo #(.WIDTH(8), .DEPTH(`TX_FIFO_DEPTH)) u_tx_fifo (
    .i_ref_clk   (i_ref_clk),
    .i_reset     (i_reset),
    .i_in_valid  (i_tx_valid),
    .o_in_ready  (o_tx_ready),
    .i_in_data   (i_tx_data),
    .o_out_valid (fifo_valid),
    .i_out_ready (start),
    .o_out_data  (fifo_data)
  );

  // Next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      sync_serial_pkg::ST_IDLE:  if (start) nxt_state = sync_serial_pkg::ST_SHIFT;
      sync_serial_pkg::ST_SHIFT: if (done || abort) nxt_state = sync_serial_pkg::ST_IDLE;
      default:                   nxt_state = sync_serial_pkg::ST_IDLE;
    endcase
  end

  // Pin synchronisers; only the second stage is read
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      sync1_ff    <= 3'h7;
      sync2_ff    <= 3'h7;
      sck_prev_ff <= 1'b1;
    end else begin
      sync1_ff    <= {bus.sck, (i_role_select_bit ? bus.m2s : bus.s2m), bus.sel_far};
      sync2_ff    <= sync1_ff;
      sck_prev_ff <= sck_in;
    end
  end

  // Frame engine: divider, edge count, clock level, shifters
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      state_ff <= sync_serial_pkg::ST_IDLE;
      div_ff   <= '0;
      edge_ff  <= 4'h0;
      sck_ff   <= 1'b0;
      tx_sh_ff <= 8'hff;
      rx_sh_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      div_ff   <= (!shifting || m_tick) ? '0 : div_ff + DIV_WIDTH'(1);
      edge_ff  <= !shifting ? 4'h0 : edge_ff + 4'(clk_edge);
      // Idle level follows polarity; each master tick toggles it
      sck_ff   <= !shifting ? i_clock_polarity_bit : (sck_ff ^ m_tick);
      if (start) tx_sh_ff <= fifo_data;
      else if (change_edge) tx_sh_ff <= {tx_sh_ff[6:0], 1'b1};
      rx_sh_ff <= rx_upd;
    end
  end

  // Flags and buffers; a set in the same cycle beats a clear
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      rx_buf_ff   <= 8'h00;
      rx_valid_ff <= 1'b0;
      fault_ff    <= 1'b0;
      ovr_ff      <= 1'b0;
      tx_irq_ff   <= 1'b0;
      rx_irq_ff   <= 1'b0;
    end else begin
      if (store) rx_buf_ff <= rx_upd;
      rx_valid_ff <= store || (rx_valid_ff && !i_rx_read);
      fault_ff    <= fault_set || (fault_ff && !fault_clr);
      ovr_ff      <= ovr_set || (ovr_ff && !i_overrun_clear);
      // Source 0 marks load, source 1 marks completion
      tx_irq_ff   <= i_tx_irq_source_select ? done : start;
      // An overrun frame is dropped and raises no receive event
      rx_irq_ff   <= store;
    end
  end

  // Pin drive: values stay put, only enables release the pins
  // Role and select take effect at once; no protected write sequence here
  assign bus.sck_dev    = sck_ff;
  assign bus.sck_dev_oe = is_master && !fault_ff;
  assign bus.m2s_dev    = tx_sh_ff[7];
  assign bus.m2s_dev_oe = is_master && !fault_ff;
  assign bus.s2m_dev    = tx_sh_ff[7];
  assign bus.s2m_dev_oe = !is_master && slave_active;

  // User-side outputs
  assign o_rx_data    = rx_buf_ff;
  assign o_rx_valid   = rx_valid_ff;
  assign o_mode_fault = fault_ff;
  assign o_overrun    = ovr_ff;
  assign o_tx_irq     = tx_irq_ff;
  assign o_rx_irq     = rx_irq_ff;
  assign o_busy       = shifting;
endmodule : sync_serial_select_mode
